//--- design/bdvs_pin_select.sv
// Functional notes
// - pair select zero disables scaling; control pins then ignored for the target.
// - select codes 1 to 28 each name one pin pair, 0/1 first, then 0/2, onward.
// - six-bit codes map linearly: 0.55 V at zero, 50 mV per count, 3.7 V top.
// - scaling enabled and selected pins at 01 apply alternate setting 1.
// - alternate setting 2 is its own read/write code, applied for its pin state.
// - a read-only field reports the scaling target currently in effect.
`timescale 1ns/1ns
`default_nettype none
module bdvs_pin_select (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [bdvs_pkg::BDVS_PIN_N-1:0] multi_purpose_control_pin,
   input wire logic [bdvs_pkg::BDVS_CODE_W-1:0] main_voltage_code,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic dynamic_voltage_scaling_on,
   output logic [bdvs_pkg::BDVS_CODE_W-1:0] target_code,
   output logic [bdvs_pkg::BDVS_MV_W-1:0] target_millivolts
);
   import bdvs_pkg::*;

   // ==========================================================
   // elaboration checks
   if (BDVS_BASE_MV + BDVS_STEP_MV * 12'(BDVS_CODE_TOP) != BDVS_TOP_MV) begin : g_bad_scale
      $error("voltage scale does not reach its top value");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [BDVS_PIN_N-1:0] pin_meta;
      logic [BDVS_PIN_N-1:0] pin_sync;
      logic [BDVS_SEL_W-1:0] pin_pair_select_field;
      logic [BDVS_SET_N-1:0][BDVS_CODE_W-1:0] alt_code;
      logic enabled;
      logic [BDVS_CODE_W-1:0] target;
      logic [BDVS_MV_W-1:0] target_mv;
      logic [7:0] rdata;
   } bdvs_state_s;

   bdvs_state_s cur;
   bdvs_state_s next_cur;
   logic pair_valid;
   logic [BDVS_PIN_IDX_W-1:0] pin_first;
   logic [BDVS_PIN_IDX_W-1:0] pin_second;
   logic [1:0] pin_state;
   logic [BDVS_CODE_W-1:0] next_target;

   bdvs_pair_decode u_pair_decode (
      .sel_code(cur.pin_pair_select_field),
      .pair_valid(pair_valid),
      .pin_first(pin_first),
      .pin_second(pin_second)
   );

   // first listed pin of the pair is the upper bit of the state
   assign pin_state = {cur.pin_sync[pin_first], cur.pin_sync[pin_second]};

   function automatic logic [7:0] read_mux(input logic [7:0] addr, input bdvs_state_s s);
      logic [7:0] d;
      d = BDVS_RDATA_UNMAPPED;
      unique case (addr)
         BDVS_ADDR_PAIR_SEL: d = {3'h0, s.pin_pair_select_field};
         BDVS_ADDR_ALT0: d = {2'h0, s.alt_code[0]};
         BDVS_ADDR_ALT1: d = {2'h0, s.alt_code[1]};
         BDVS_ADDR_ALT2: d = {2'h0, s.alt_code[2]};
         BDVS_ADDR_ALT3: d = {2'h0, s.alt_code[3]};
         BDVS_ADDR_READBACK: d = {2'h0, s.target};
         default: d = BDVS_RDATA_UNMAPPED;
      endcase
      return d;
   endfunction : read_mux

   // ==========================================================
   // next state
   always_comb begin
      next_cur = cur;
      // pins come from the host, asynchronous to ref_clk
      next_cur.pin_meta = multi_purpose_control_pin;
      next_cur.pin_sync = cur.pin_meta;
      if (reg_wr) begin
         unique case (reg_addr)
            BDVS_ADDR_PAIR_SEL: next_cur.pin_pair_select_field = reg_wdata[BDVS_SEL_W-1:0];
            BDVS_ADDR_ALT0: next_cur.alt_code[0] = reg_wdata[BDVS_CODE_W-1:0];
            BDVS_ADDR_ALT1: next_cur.alt_code[1] = reg_wdata[BDVS_CODE_W-1:0];
            BDVS_ADDR_ALT2: next_cur.alt_code[2] = reg_wdata[BDVS_CODE_W-1:0];
            BDVS_ADDR_ALT3: next_cur.alt_code[3] = reg_wdata[BDVS_CODE_W-1:0];
            // readback is read-only, unmapped writes are dropped
            default: next_cur = next_cur;
         endcase
      end
      next_cur.enabled = pair_valid;
      if (pair_valid) begin
         next_target = cur.alt_code[pin_state];
      end else begin
         next_target = main_voltage_code;
      end
      next_cur.target = next_target;
      next_cur.target_mv = BDVS_BASE_MV + BDVS_STEP_MV * BDVS_MV_W'(next_target);
      if (reg_rd) begin
         next_cur.rdata = read_mux(reg_addr, cur);
      end
   end

   // ==========================================================
   // registers; no documented reset values, zero chosen, except millivolts at 550 to match code zero
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cur.pin_meta <= '0;
         cur.pin_sync <= '0;
         cur.pin_pair_select_field <= BDVS_SEL_RESET;
         cur.alt_code <= {BDVS_SET_N{BDVS_CODE_RESET}};
         cur.enabled <= 1'b0;
         cur.target <= BDVS_CODE_RESET;
         cur.target_mv <= BDVS_BASE_MV;
         cur.rdata <= BDVS_RDATA_UNMAPPED;
      end else begin
         cur <= next_cur;
      end
   end

   assign reg_rdata = cur.rdata;
   assign dynamic_voltage_scaling_on = cur.enabled;
   assign target_code = cur.target;
   assign target_millivolts = cur.target_mv;

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_select_off;
      cur.pin_pair_select_field == BDVS_SEL_DISABLED;
   endsequence

   sequence s_scaling_at(logic [1:0] st);
      pair_valid && pin_state == st;
   endsequence

   property p_disabled_uses_main;
      s_select_off |=> !dynamic_voltage_scaling_on && target_code == $past(main_voltage_code);
   endproperty
   a_disabled_uses_main: assert property (p_disabled_uses_main) else $error("pins steered target while disabled");

   property p_pair_zero_one;
      cur.pin_pair_select_field == 5'h01 |-> pin_first == 3'h0 && pin_second == 3'h1;
   endproperty
   a_pair_zero_one: assert property (p_pair_zero_one) else $error("first code not pins zero and one");

   property p_pair_zero_two;
      cur.pin_pair_select_field == 5'h02 |-> pin_first == 3'h0 && pin_second == 3'h2;
   endproperty
   a_pair_zero_two: assert property (p_pair_zero_two) else $error("second code not pins zero and two");

   property p_linear_mv;
      target_millivolts == BDVS_BASE_MV + BDVS_STEP_MV * BDVS_MV_W'(target_code);
   endproperty
   a_linear_mv: assert property (p_linear_mv) else $error("millivolt output off the linear scale");

   property p_state_one;
      s_scaling_at(2'b01) |=> target_code == $past(cur.alt_code[1]) && dynamic_voltage_scaling_on;
   endproperty
   a_state_one: assert property (p_state_one) else $error("pin state 01 did not apply setting 1");

   property p_state_two;
      s_scaling_at(2'b10) |=> target_code == $past(cur.alt_code[2]);
   endproperty
   a_state_two: assert property (p_state_two) else $error("pin state 10 did not apply setting 2");

   property p_readback;
      reg_rd && reg_addr == BDVS_ADDR_READBACK |=> reg_rdata == {2'h0, $past(target_code)};
   endproperty
   a_readback: assert property (p_readback) else $error("readback differs from target in effect");

   sequence s_pair_low;
      pair_valid && !multi_purpose_control_pin[pin_first] && !multi_purpose_control_pin[pin_second];
   endsequence

   // only the selected pair matters, the other pins may wander; pins land three edges later
   property p_pins_to_target;
      s_pair_low ##1 $stable(cur.pin_pair_select_field)
         ##1 $stable(cur.pin_pair_select_field) && pair_valid |=> target_code == $past(cur.alt_code[0]);
   endproperty
   a_pins_to_target: assert property (p_pins_to_target) else $error("pins low did not select setting 0");
endmodule : bdvs_pin_select
`default_nettype wire

//--- common/bdvs_pkg.sv
package bdvs_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] BDVS_ADDR_PAIR_SEL = 8'h3a;
   localparam logic [7:0] BDVS_ADDR_ALT0 = 8'h3b;
   localparam logic [7:0] BDVS_ADDR_ALT1 = 8'h3c;
   localparam logic [7:0] BDVS_ADDR_ALT2 = 8'h3d;
   localparam logic [7:0] BDVS_ADDR_ALT3 = 8'h3e;
   localparam logic [7:0] BDVS_ADDR_READBACK = 8'h3f;
   // ==========================================================
   // field layout and reset values
   localparam int BDVS_SEL_W = 5;
   localparam int BDVS_CODE_W = 6;
   localparam int BDVS_PIN_N = 8;
   localparam int BDVS_PIN_IDX_W = 3;
   localparam int BDVS_SET_N = 4;
   localparam logic [4:0] BDVS_SEL_DISABLED = 5'h00;
   localparam logic [4:0] BDVS_SEL_FIRST = 5'h01;
   localparam logic [4:0] BDVS_SEL_RESET = 5'h00;
   localparam logic [5:0] BDVS_CODE_RESET = 6'h00;
   localparam logic [7:0] BDVS_RDATA_UNMAPPED = 8'h00;
   // ==========================================================
   // voltage encoding, millivolts
   localparam int BDVS_MV_W = 12;
   localparam logic [11:0] BDVS_BASE_MV = 12'd550;
   localparam logic [11:0] BDVS_STEP_MV = 12'd50;
   localparam logic [11:0] BDVS_TOP_MV = 12'd3700;
   localparam logic [5:0] BDVS_CODE_TOP = 6'h3f;
   // ==========================================================
   // latency, pin edge to target register
   localparam int BDVS_SYNC_STAGES = 2;
   localparam int BDVS_PIN_TO_TARGET = 3;
endpackage : bdvs_pkg

//--- design/bdvs_pair_decode.sv
`timescale 1ns/1ns
`default_nettype none
module bdvs_pair_decode (
   input wire logic [bdvs_pkg::BDVS_SEL_W-1:0] sel_code,
   output logic pair_valid,
   output logic [bdvs_pkg::BDVS_PIN_IDX_W-1:0] pin_first,
   output logic [bdvs_pkg::BDVS_PIN_IDX_W-1:0] pin_second
);
   import bdvs_pkg::*;

   // ==========================================================
   // code n names the n-th pair in lexicographic order
   always_comb begin
      logic [BDVS_SEL_W-1:0] n;
      n = BDVS_SEL_FIRST;
      pair_valid = 1'b0;
      pin_first = '0;
      pin_second = '0;
      for (int a = 0; a < BDVS_PIN_N - 1; a++) begin
         for (int b = a + 1; b < BDVS_PIN_N; b++) begin
            if (sel_code == n) begin
               pair_valid = 1'b1;
               pin_first = a[BDVS_PIN_IDX_W-1:0];
               pin_second = b[BDVS_PIN_IDX_W-1:0];
            end
            n = n + 5'h01;
         end
      end
      // zero and the codes past the 28th pair select nothing
      if (sel_code == BDVS_SEL_DISABLED) begin
         pair_valid = 1'b0;
      end
   end
endmodule : bdvs_pair_decode
`default_nettype wire

//--- bench/bdvs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module bdvs_host_model (
   input wire logic ref_clk,
   input wire logic [2:0] pin_a,
   input wire logic [2:0] pin_b,
   input wire logic [1:0] state,
   output logic [7:0] pins
);
   logic [7:0] noise = 8'h5a;
   // ==========================================
   // unused pins wander so a wrong pair shows up
   always_ff @(negedge ref_clk) begin
      noise <= ~noise;
   end
   always_comb begin
      pins = noise;
      pins[pin_a] = state[1];
      pins[pin_b] = state[0];
   end
endmodule : bdvs_host_model
`default_nettype wire

//--- bench/bdvs_pin_select_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module bdvs_pin_select_tb_top;
   import bdvs_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] pins;
   logic [5:0] main_code = 6'h2a;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic dvs_on;
   logic [5:0] tcode;
   logic [11:0] tmv;
   logic [2:0] pin_a = 3'h0;
   logic [2:0] pin_b = 3'h1;
   logic [1:0] state = 2'h0;
   int n_mismatch = 0;
   int checked = 0;
   logic [5:0] alt [4] = '{6'h11, 6'h22, 6'h33, 6'h3f};
   bdvs_host_model i_bdvs_host_model (.ref_clk(ref_clk), .pin_a(pin_a), .pin_b(pin_b), .state(state), .pins(pins));
   bdvs_pin_select i_bdvs_pin_select (.ref_clk(ref_clk), .reset(reset), .multi_purpose_control_pin(pins),
      .main_voltage_code(main_code), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dynamic_voltage_scaling_on(dvs_on), .target_code(tcode),
      .target_millivolts(tmv));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // ==========================================
   // helpers
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
   // settle four edges: three cover the pin path, two a register write
   task automatic expect_target(input logic [5:0] code, input logic on);
      logic [7:0] d;
      repeat (BDVS_PIN_TO_TARGET + 1) @(negedge ref_clk);
      chk({6'h00, tcode}, {6'h00, code}, "target");
      chk({11'h000, dvs_on}, {11'h000, on}, "enable");
      chk(tmv, BDVS_BASE_MV + BDVS_STEP_MV * {6'h00, code}, "millivolts");
      rd(BDVS_ADDR_READBACK, d);
      chk({4'h0, d}, {6'h00, code}, "readback");
   endtask : expect_target
   // ==========================================
   // scenarios
   task automatic t_regs();
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         wr(BDVS_ADDR_ALT0 + 8'(i), 8'hff);
         rd(BDVS_ADDR_ALT0 + 8'(i), d);
         chk({4'h0, d}, 12'h03f, "alt width");
      end
      wr(BDVS_ADDR_PAIR_SEL, 8'hff);
      rd(BDVS_ADDR_PAIR_SEL, d);
      chk({4'h0, d}, 12'h01f, "select width");
      wr(BDVS_ADDR_READBACK, 8'h15);
      expect_target(main_code, 1'b0);
      rd(8'h10, d);
      chk({4'h0, d}, 12'h000, "unmapped");
      $display("test regs done");
   endtask : t_regs
   task automatic t_disabled();
      wr(BDVS_ADDR_PAIR_SEL, 8'h00);
      for (int s = 0; s < 4; s++) begin
         state = 2'(s);
         main_code = 6'h2a + 6'(s);
         expect_target(main_code, 1'b0);
      end
      $display("test disabled done");
   endtask : t_disabled
   task automatic t_pairs();
      logic [4:0] code;
      code = 5'h01;
      for (int i = 0; i < 4; i++) begin
         wr(BDVS_ADDR_ALT0 + 8'(i), {2'h0, alt[i]});
      end
      for (int a = 0; a < 7; a++) begin
         for (int b = a + 1; b < 8; b++) begin
            wr(BDVS_ADDR_PAIR_SEL, {3'h0, code});
            pin_a = 3'(a);
            pin_b = 3'(b);
            for (int s = 0; s < 4; s++) begin
               state = 2'(s);
               expect_target(alt[s], 1'b1);
            end
            code++;
         end
      end
      $display("test pairs done");
   endtask : t_pairs
   // reset in mid-run, with scaling active and settings loaded
   task automatic t_reset();
      logic [7:0] d;
      @(negedge ref_clk);
      reset = 1'b1;
      @(negedge ref_clk);
      chk(tmv, BDVS_BASE_MV, "reset millivolts");
      chk({6'h00, tcode}, 12'h000, "reset target");
      chk({11'h000, dvs_on}, 12'h000, "reset enable");
      reset = 1'b0;
      rd(BDVS_ADDR_ALT2, d);
      chk({4'h0, d}, 12'h000, "reset setting");
      expect_target(main_code, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      t_regs();
      t_disabled();
      t_pairs();
      t_reset();
      print_verdict();
   end
endmodule : bdvs_pin_select_tb_top
`default_nettype wire
